// File: design/rwm_params.svh
`ifndef RWM_PARAMS_SVH
`define RWM_PARAMS_SVH
`define RWM_WSEL_ADDR 16'h0014
`define RWM_WSEL2_ADDR 16'h0015
`define RWM_SP_LO_ADDR 16'h0018
`define RWM_SP_HI_ADDR 16'h0019
`define RWM_CPU_SFR_TOP 16'h0017
`define RWM_LRF_TOP 16'h00ff
`define RWM_WSEL_RST 8'h00
`define RWM_WSEL2_RST 8'h00
`define RWM_SP_RST 16'h0000
`define RWM_WIN1_BASE_32 16'h00e0
`define RWM_WIN1_BASE_64 16'h00c0
`define RWM_WIN1_BASE_128 16'h0080
`define RWM_WIN2_BASE_32 16'h0060
`define RWM_WIN2_BASE_64 16'h0040
`define RWM_URF_BASE 16'h0100
`define RWM_PSFR_BASE 16'h1f00
`define RWM_MMSFR_LO 16'h1fe0
`define RWM_MMSFR_HI 16'h1fff
`define RWM_CODE32_URF_LO 7'h48
`define RWM_CODE32_URF_HI 7'h5f
`define RWM_CODE32_PSFR_LO 7'h78
`define RWM_CODE32_PSFR_HI 7'h7f
`define RWM_CODE64_URF_LO 7'h24
`define RWM_CODE64_URF_HI 7'h2f
`define RWM_CODE64_PSFR_LO 7'h3c
`define RWM_CODE64_PSFR_HI 7'h3f
`define RWM_CODE128_URF_LO 7'h12
`define RWM_CODE128_URF_HI 7'h17
`define RWM_CODE128_PSFR_LO 7'h1e
`define RWM_CODE128_PSFR_HI 7'h1f
`define RWM_BLANK_DATA 8'hff
`define RWM_HOLD_BIT 7
`define RWM_STEP_64K 16'h0002
`define RWM_STEP_1M 16'h0004
`endif

// File: design/rwm_pkg.sv
package rwm_pkg;
  typedef enum logic [1:0] {
    RWM_MODE_DIRECT = 2'b00,
    RWM_MODE_INDIRECT = 2'b01,
    RWM_MODE_INDEXED = 2'b10
  } rwm_mode_e;

  typedef enum logic [1:0] {
    RWM_SZ_NONE = 2'b00,
    RWM_SZ_32 = 2'b01,
    RWM_SZ_64 = 2'b10,
    RWM_SZ_128 = 2'b11
  } rwm_size_e;

  typedef enum logic [1:0] {
    RWM_ST_IDLE = 2'b00,
    RWM_ST_PUSH = 2'b01,
    RWM_ST_POP = 2'b10
  } rwm_state_e;

  // One register-file access issued by the arithmetic unit.
  typedef struct packed {
    logic valid;
    logic write;
    rwm_mode_e mode;
    logic [15:0] addr;
    logic [7:0] wdata;
  } rwm_req_s;

  // One access as presented to the register RAM and peripheral space.
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } rwm_mem_s;

  // Decoded window: size, segment base in high memory.
  typedef struct packed {
    rwm_size_e size;
    logic [15:0] seg_base;
  } rwm_win_s;
endpackage

// File: design/rwm_top.sv
// Contract
// - Stack pointer word sits at 0018H low byte and 0019H high byte.
// - Call or interrupt entry first lowers pointer by two or four per mode.
// - Then return address goes to stack at new pointer, target to PC.
// - Return loads PC from stack top and raises pointer by two or four on the same edge.
// - Locations 0000 to 0017H are CPU registers and are never remapped.
// - Only upper file or peripheral segments are windowed, for direct accesses.
// - Primary select bit 7 is bus hold enable; bits 6 to 0 choose window.
// - Primary window covers E0, C0 or 80 through FFH by size.
// - Second window is 32 or 64 bytes at 0060 or 0040 through 007FH.
// - Both windows may be active together; 001A to 003FH stays plain RAM.
// - Upper file codes 48H, 24H, 12H ranges pick ascending segments from 0100H.
// - Peripheral codes 78H, 3CH, 1EH ranges pick ascending segments from 1F00H.
// - Windowed address is segment base plus offset from window base.
// - Optional variant blanks windowed accesses to 1FE0 to 1FFFH: reads FFH, writes dropped.
// - Second select sits at 0015H, resets to 00H, bit 7 reserved.
// - A select code of zero disables its window.
// - Indirect and indexed accesses always reach the true address.
`timescale 1ns/1ps
`include "rwm_params.svh"
module rwm_top #(
  parameter bit BLANK_MMSFR = 1'b0,
  parameter int PC_WIDTH = 20
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire rwm_pkg::rwm_req_s cpu_req,
  output logic cpu_ready,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  output rwm_pkg::rwm_mem_s mem_req,
  input wire logic mem_ready,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rvalid,
  input wire logic mode_1m,
  input wire logic call_start,
  input wire logic ret_start,
  input wire logic [PC_WIDTH-1:0] next_pc,
  input wire logic [PC_WIDTH-1:0] target_pc,
  output logic [PC_WIDTH-1:0] pc_q,
  output logic pc_load,
  output logic stack_busy,
  output logic bus_hold_enable,
  output logic [15:0] stack_top_pointer_q
);
  // The program counter must hold at least the 16-bit stack word and at most 32 bits.
  initial begin
    if (PC_WIDTH < 16 || PC_WIDTH > 32) begin
      $error("PC_WIDTH must lie between 16 and 32");
    end
  end

  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_n;
  logic [7:0] window_select_q;
  logic [7:0] window_select_second_q;
  rwm_pkg::rwm_win_s win1;
  rwm_pkg::rwm_win_s win2;
  rwm_pkg::rwm_state_e state_q;
  logic [2:0] byte_q;
  logic [15:0] sp_d;
  logic [15:0] step;
  logic [2:0] nbytes;
  logic [31:0] pop_q;
  logic [15:0] mapped;
  logic direct;
  logic hit1;
  logic hit2;
  logic blank;
  logic lrf_reg;
  logic busy;
  logic blank_rd_q;
  logic reg_rd_q;
  logic [7:0] reg_rd_data_q;
  logic stk_rd_q;
  logic [15:0] stk_addr;

  // Reset release through two flops.
  // Every register then leaves reset on the same edge, whatever reset_n does between edges.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // Decoders; the second window never offers 128 bytes.
  rwm_win_decode #(.ALLOW_128(1'b1)) u_dec1 (
    .window_code(window_select_q[6:0]),
    .win(win1)
  );
  rwm_win_decode #(.ALLOW_128(1'b0)) u_dec2 (
    .window_code(window_select_second_q[6:0]),
    .win(win2)
  );

  // Lower window base for a given size and primary or second window.
  // A disabled window gets a base above the lower file, so no address can hit it.
  function automatic logic [15:0] win_base(input rwm_pkg::rwm_size_e sz, input logic second);
    win_base = `RWM_LRF_TOP + 16'h0001;
    case (sz)
      rwm_pkg::RWM_SZ_32: win_base = second ? `RWM_WIN2_BASE_32 : `RWM_WIN1_BASE_32;
      rwm_pkg::RWM_SZ_64: win_base = second ? `RWM_WIN2_BASE_64 : `RWM_WIN1_BASE_64;
      rwm_pkg::RWM_SZ_128: win_base = `RWM_WIN1_BASE_128;
      default: win_base = `RWM_LRF_TOP + 16'h0001;
    endcase
  endfunction

  // Inside test: true when addr lies in [base, top].
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Address translation for CPU accesses.
  // Only direct accesses look at the windows; indirect and indexed ones pass through.
  // The CPU register area sits below both windows, so it is never redirected.
  always_comb begin
    direct = cpu_req.mode == rwm_pkg::RWM_MODE_DIRECT;
    hit1 = direct && win1.size != rwm_pkg::RWM_SZ_NONE &&
           in_range(cpu_req.addr, win_base(win1.size, 1'b0), `RWM_LRF_TOP);
    hit2 = direct && win2.size != rwm_pkg::RWM_SZ_NONE &&
           in_range(cpu_req.addr, win_base(win2.size, 1'b1),
                    `RWM_WIN2_BASE_32 + 16'h001f);
    mapped = cpu_req.addr;
    if (cpu_req.addr > `RWM_CPU_SFR_TOP) begin
      if (hit1) begin
        mapped = win1.seg_base + (cpu_req.addr - win_base(win1.size, 1'b0));
      end else if (hit2) begin
        mapped = win2.seg_base + (cpu_req.addr - win_base(win2.size, 1'b1));
      end
    end
    blank = BLANK_MMSFR && (hit1 || hit2) && cpu_req.addr > `RWM_CPU_SFR_TOP &&
            in_range(mapped, `RWM_MMSFR_LO, `RWM_MMSFR_HI);
    lrf_reg = !(hit1 || hit2) && (cpu_req.addr == `RWM_WSEL_ADDR ||
              cpu_req.addr == `RWM_WSEL2_ADDR || cpu_req.addr == `RWM_SP_LO_ADDR ||
              cpu_req.addr == `RWM_SP_HI_ADDR);
  end

  // Ready stays low while a push or pop owns the memory port, so CPU traffic waits.
  assign busy = state_q != rwm_pkg::RWM_ST_IDLE;
  assign stack_busy = busy;
  assign bus_hold_enable = window_select_q[`RWM_HOLD_BIT];
  assign cpu_ready = !busy && (lrf_reg || blank || mem_ready);

  // Window select registers, written by direct or true address.
  // Bit 7 of the second select is stored as zero, so it always reads back clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      window_select_q <= `RWM_WSEL_RST;
      window_select_second_q <= `RWM_WSEL2_RST;
    end else if (cpu_req.valid && cpu_ready && cpu_req.write && lrf_reg) begin
      if (cpu_req.addr == `RWM_WSEL_ADDR) begin
        window_select_q <= cpu_req.wdata;
      end
      if (cpu_req.addr == `RWM_WSEL2_ADDR) begin
        window_select_second_q <= {1'b0, cpu_req.wdata[6:0]};
      end
    end
  end

  // Stack step size by addressing mode.
  always_comb begin
    step = mode_1m ? `RWM_STEP_1M : `RWM_STEP_64K;
    nbytes = mode_1m ? 3'd4 : 3'd2;
    sp_d = stack_top_pointer_q;
    if (state_q == rwm_pkg::RWM_ST_IDLE && call_start) begin
      sp_d = stack_top_pointer_q - step;
    end else if (state_q == rwm_pkg::RWM_ST_POP && stk_rd_q && mem_rvalid &&
                 byte_q == nbytes - 3'd1) begin
      // The pointer rises only once the last popped byte has really arrived.
      sp_d = stack_top_pointer_q + step;
    end
  end

  // Stack pointer storage at 0018H/0019H.
  // A stack update wins over a CPU write in the same cycle; on the call_start cycle the CPU write is accepted but dropped.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_top_pointer_q <= `RWM_SP_RST;
    end else if (busy || call_start) begin
      stack_top_pointer_q <= sp_d;
    end else if (cpu_req.valid && cpu_ready && cpu_req.write && lrf_reg) begin
      if (cpu_req.addr == `RWM_SP_LO_ADDR) begin
        stack_top_pointer_q[7:0] <= cpu_req.wdata;
      end
      if (cpu_req.addr == `RWM_SP_HI_ADDR) begin
        stack_top_pointer_q[15:8] <= cpu_req.wdata;
      end
    end
  end

  // Push and pop sequencer, one byte per accepted memory cycle.
  // A pop waits for each answer before issuing the next read, so one read is in flight.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= rwm_pkg::RWM_ST_IDLE;
      byte_q <= 3'd0;
      stk_rd_q <= 1'b0;
    end else begin
      case (state_q)
        rwm_pkg::RWM_ST_IDLE: begin
          byte_q <= 3'd0;
          stk_rd_q <= 1'b0;
          if (call_start) begin
            state_q <= rwm_pkg::RWM_ST_PUSH;
          end else if (ret_start) begin
            state_q <= rwm_pkg::RWM_ST_POP;
          end
        end
        rwm_pkg::RWM_ST_PUSH: begin
          if (mem_ready) begin
            byte_q <= byte_q + 3'd1;
            if (byte_q == nbytes - 3'd1) begin
              state_q <= rwm_pkg::RWM_ST_IDLE;
            end
          end
        end
        rwm_pkg::RWM_ST_POP: begin
          if (stk_rd_q) begin
            if (mem_rvalid) begin
              stk_rd_q <= 1'b0;
              byte_q <= byte_q + 3'd1;
              if (byte_q == nbytes - 3'd1) begin
                state_q <= rwm_pkg::RWM_ST_IDLE;
              end
            end
          end else if (mem_ready) begin
            stk_rd_q <= 1'b1;
          end
        end
        default: state_q <= rwm_pkg::RWM_ST_IDLE;
      endcase
    end
  end

  // Popped bytes are collected, lowest address first.
  // The return address is kept little-endian, in the order the push wrote it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pop_q <= 32'h00000000;
    end else if (state_q == rwm_pkg::RWM_ST_POP && stk_rd_q && mem_rvalid) begin
      pop_q[byte_q*8 +: 8] <= mem_rdata;
    end
  end

  // Program counter: target after push, stack value after pop.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= '0;
      pc_load <= 1'b0;
    end else begin
      pc_load <= 1'b0;
      if (state_q == rwm_pkg::RWM_ST_PUSH && mem_ready && byte_q == nbytes - 3'd1) begin
        pc_q <= target_pc;
        pc_load <= 1'b1;
      end else if (state_q == rwm_pkg::RWM_ST_POP && stk_rd_q && mem_rvalid &&
                   byte_q == nbytes - 3'd1) begin
        // The 64-Kbyte mode returns a 16-bit word; the upper PC bits are cleared.
        if (mode_1m) begin
          pc_q <= PC_WIDTH'({mem_rdata, pop_q[23:0]});
        end else begin
          pc_q <= PC_WIDTH'({mem_rdata, pop_q[7:0]});
        end
        pc_load <= 1'b1;
      end
    end
  end

  // Stack byte address grows upward from the pointer.
  // During a push the pointer already holds its lowered value, so bytes fill upward.
  assign stk_addr = stack_top_pointer_q + {13'h0000, byte_q};

  // Memory request mux: stack sequencer has priority over CPU accesses.
  // A blanked access never reaches memory; its read answer comes from the local path.
  always_comb begin
    mem_req.valid = 1'b0;
    mem_req.write = 1'b0;
    mem_req.addr = 16'h0000;
    mem_req.wdata = 8'h00;
    if (state_q == rwm_pkg::RWM_ST_PUSH) begin
      mem_req.valid = 1'b1;
      mem_req.write = 1'b1;
      mem_req.addr = stk_addr;
      mem_req.wdata = 8'(32'(next_pc) >> (byte_q * 8));
    end else if (state_q == rwm_pkg::RWM_ST_POP) begin
      mem_req.valid = !stk_rd_q;
      mem_req.addr = stk_addr;
    end else if (cpu_req.valid && !lrf_reg && !blank) begin
      mem_req.valid = 1'b1;
      mem_req.write = cpu_req.write;
      mem_req.addr = mapped;
      mem_req.wdata = cpu_req.wdata;
    end
  end

  // Local register reads and blanked reads answer two cycles after acceptance, as memory reads do.
  // Register data is captured at acceptance, so a write that follows cannot alter it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blank_rd_q <= 1'b0;
      reg_rd_q <= 1'b0;
      reg_rd_data_q <= 8'h00;
    end else begin
      blank_rd_q <= cpu_req.valid && cpu_ready && !cpu_req.write && blank;
      reg_rd_q <= cpu_req.valid && cpu_ready && !cpu_req.write && lrf_reg;
      case (cpu_req.addr)
        `RWM_WSEL_ADDR: reg_rd_data_q <= window_select_q;
        `RWM_WSEL2_ADDR: reg_rd_data_q <= window_select_second_q;
        `RWM_SP_LO_ADDR: reg_rd_data_q <= stack_top_pointer_q[7:0];
        `RWM_SP_HI_ADDR: reg_rd_data_q <= stack_top_pointer_q[15:8];
        default: reg_rd_data_q <= 8'h00;
      endcase
    end
  end

  // CPU read data: blanked range, local register, or memory answer.
  // Memory answers to stack reads are kept away from the CPU read port.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rdata <= 8'h00;
      cpu_rvalid <= 1'b0;
    end else begin
      cpu_rvalid <= 1'b0;
      if (blank_rd_q) begin
        cpu_rdata <= `RWM_BLANK_DATA;
        cpu_rvalid <= 1'b1;
      end else if (reg_rd_q) begin
        cpu_rdata <= reg_rd_data_q;
        cpu_rvalid <= 1'b1;
      end else if (mem_rvalid && state_q != rwm_pkg::RWM_ST_POP) begin
        cpu_rdata <= mem_rdata;
        cpu_rvalid <= 1'b1;
      end
    end
  end
endmodule

// File: design/rwm_win_decode.sv
`timescale 1ns/1ps
`include "rwm_params.svh"
module rwm_win_decode #(
  parameter bit ALLOW_128 = 1'b1
) (
  input wire logic [6:0] window_code,
  output rwm_pkg::rwm_win_s win
);
  // Maps a window code to size and segment base; unknown codes disable the window.
  always_comb begin
    win.size = rwm_pkg::RWM_SZ_NONE;
    win.seg_base = 16'h0000;
    if (window_code >= `RWM_CODE32_URF_LO && window_code <= `RWM_CODE32_URF_HI) begin
      win.size = rwm_pkg::RWM_SZ_32;
      win.seg_base = `RWM_URF_BASE + {4'h0, window_code - `RWM_CODE32_URF_LO, 5'h00};
    end else if (window_code >= `RWM_CODE32_PSFR_LO && window_code <= `RWM_CODE32_PSFR_HI) begin
      win.size = rwm_pkg::RWM_SZ_32;
      win.seg_base = `RWM_PSFR_BASE + {4'h0, window_code - `RWM_CODE32_PSFR_LO, 5'h00};
    end else if (window_code >= `RWM_CODE64_URF_LO && window_code <= `RWM_CODE64_URF_HI) begin
      win.size = rwm_pkg::RWM_SZ_64;
      win.seg_base = `RWM_URF_BASE + {3'h0, window_code - `RWM_CODE64_URF_LO, 6'h00};
    end else if (window_code >= `RWM_CODE64_PSFR_LO && window_code <= `RWM_CODE64_PSFR_HI) begin
      win.size = rwm_pkg::RWM_SZ_64;
      win.seg_base = `RWM_PSFR_BASE + {3'h0, window_code - `RWM_CODE64_PSFR_LO, 6'h00};
    end else if (ALLOW_128 && window_code >= `RWM_CODE128_URF_LO &&
                 window_code <= `RWM_CODE128_URF_HI) begin
      win.size = rwm_pkg::RWM_SZ_128;
      win.seg_base = `RWM_URF_BASE + {2'h0, window_code - `RWM_CODE128_URF_LO, 7'h00};
    end else if (ALLOW_128 && window_code >= `RWM_CODE128_PSFR_LO &&
                 window_code <= `RWM_CODE128_PSFR_HI) begin
      win.size = rwm_pkg::RWM_SZ_128;
      win.seg_base = `RWM_PSFR_BASE + {2'h0, window_code - `RWM_CODE128_PSFR_LO, 7'h00};
    end
  end
endmodule

// File: verif/rwm_mem_model.sv
`timescale 1ns/1ps
module rwm_mem_model (
  input wire logic clk,
  input wire rwm_pkg::rwm_mem_s req,
  input wire logic slow,
  output logic ready,
  output logic [7:0] rdata,
  output logic rvalid
);
  // Register RAM and peripheral space of page 00H, where the stack lives.
  logic [7:0] mem [0:65535];
  logic tick_q = 1'b0;

  // In slow mode only every other cycle accepts, to stretch stack transfers.
  always @(posedge clk) begin
    tick_q <= !tick_q;
  end
  assign ready = !slow || tick_q;

  // A read answers one cycle after acceptance; otherwise the data lines toggle.
  always @(posedge clk) begin
    rvalid <= 1'b0;
    rdata <= ~rdata;
    if (req.valid && ready) begin
      if (req.write) begin
        mem[req.addr] <= req.wdata;
      end else begin
        rvalid <= 1'b1;
        rdata <= mem[req.addr];
      end
    end
  end

  initial begin
    rdata = 8'h00;
    rvalid = 1'b0;
  end
endmodule

// File: verif/rwm_top_sva.sv
`timescale 1ns/1ps
module rwm_top_chk #(
  parameter int PC_WIDTH = 20
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire rwm_pkg::rwm_req_s cpu_req,
  input wire logic cpu_ready,
  input wire logic cpu_rvalid,
  input wire rwm_pkg::rwm_mem_s mem_req,
  input wire logic mode_1m,
  input wire logic call_start,
  input wire logic ret_start,
  input wire logic [PC_WIDTH-1:0] target_pc,
  input wire logic [PC_WIDTH-1:0] pc_q,
  input wire logic pc_load,
  input wire logic stack_busy,
  input wire logic bus_hold_enable,
  input wire logic [15:0] stack_top_pointer_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic take, loc, dir, push_q, pop_q;
  logic [15:0] step, sp_ret_q, a;

  // Decoding of the accepted access and of the mode step.
  assign a = cpu_req.addr;
  assign take = cpu_req.valid && cpu_ready;
  assign dir = cpu_req.mode == rwm_pkg::RWM_MODE_DIRECT;
  assign loc = a == 16'h0014 || a == 16'h0015 || a == 16'h0018 || a == 16'h0019;
  assign step = mode_1m ? 16'h0004 : 16'h0002;

  // Tracks which stack operation runs, ending at its program counter load.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      push_q <= 1'b0;
      pop_q <= 1'b0;
      sp_ret_q <= 16'h0000;
    end else if (!stack_busy && call_start) begin
      push_q <= 1'b1;
    end else if (!stack_busy && ret_start) begin
      pop_q <= 1'b1;
      sp_ret_q <= stack_top_pointer_q;
    end else if (pc_load) begin
      push_q <= 1'b0;
      pop_q <= 1'b0;
    end
  end

  a_sfr_no_remap: assert property (take && a <= 16'h0013 |->
    mem_req.valid && mem_req.addr == a) else $error("CPU register access remapped");
  a_indirect_true: assert property (take && !dir && !loc |->
    mem_req.valid && mem_req.addr == a) else $error("Indirect access address altered");
  a_local_read: assert property (take && loc && !cpu_req.write |->
    !mem_req.valid ##2 cpu_rvalid) else $error("Local register read misrouted");
  a_hold_bit: assert property (take && dir && cpu_req.write && a == 16'h0014 |=>
    bus_hold_enable == $past(cpu_req.wdata[7])) else $error("Hold enable not from bit 7");
  a_call_step: assert property (call_start && !stack_busy |=>
    stack_top_pointer_q == $past(stack_top_pointer_q) - $past(step))
    else $error("Pointer not lowered by step");
  a_push_slot: assert property (push_q && mem_req.valid |->
    mem_req.write && mem_req.addr - stack_top_pointer_q < step)
    else $error("Push outside new stack slot");
  a_call_target: assert property (push_q && pc_load |-> ##[0:1] pc_q == target_pc)
    else $error("Call target not loaded");
  a_pop_slot: assert property (pop_q && mem_req.valid |->
    !mem_req.write && mem_req.addr - sp_ret_q < step) else $error("Pop outside stack top");
  a_ret_step: assert property (pop_q && pc_load |->
    ##[0:1] stack_top_pointer_q == sp_ret_q + step) else $error("Pointer not raised by step");

  c_call: cover property (push_q && pc_load);
  c_ret: cover property (pop_q && pc_load);
  c_window: cover property (take && dir && mem_req.valid && mem_req.addr >= 16'h0100);
endmodule

bind rwm_top rwm_top_chk #(.PC_WIDTH(PC_WIDTH)) chk_u (.clk(clk), .reset_n(reset_n),
  .cpu_req(cpu_req), .cpu_ready(cpu_ready), .cpu_rvalid(cpu_rvalid), .mem_req(mem_req),
  .mode_1m(mode_1m), .call_start(call_start), .ret_start(ret_start), .target_pc(target_pc),
  .pc_q(pc_q), .pc_load(pc_load), .stack_busy(stack_busy),
  .bus_hold_enable(bus_hold_enable), .stack_top_pointer_q(stack_top_pointer_q));

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
  localparam rwm_pkg::rwm_mode_e DR = rwm_pkg::RWM_MODE_DIRECT;
  localparam rwm_pkg::rwm_mode_e IN = rwm_pkg::RWM_MODE_INDIRECT;
  localparam rwm_pkg::rwm_mode_e IX = rwm_pkg::RWM_MODE_INDEXED;
  // Window table: select register, code, direct address, physical address.
  localparam logic [15:0] SEL [11] = '{16'h14, 16'h15, 16'h14, 16'h15, 16'h14, 16'h14,
    16'h14, 16'h14, 16'h15, 16'h14, 16'h15};
  localparam logic [7:0] CODE [11] = '{8'h4a, 8'h4a, 8'h25, 8'h25, 8'h17, 8'h12, 8'h1f,
    8'h3c, 8'h78, 8'h7f, 8'h2f};
  localparam logic [15:0] LA [11] = '{16'h00eb, 16'h006b, 16'h00c1, 16'h0041, 16'h0080,
    16'h00ff, 16'h0082, 16'h00c5, 16'h0063, 16'h00ff, 16'h007f};
  localparam logic [15:0] PA [11] = '{16'h014b, 16'h014b, 16'h0141, 16'h0141, 16'h0380,
    16'h017f, 16'h1f82, 16'h1f05, 16'h1f03, 16'h1fff, 16'h03ff};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  rwm_pkg::rwm_req_s cpu_req = '0;
  rwm_pkg::rwm_mem_s mem_req;
  logic cpu_ready, cpu_rvalid, mem_ready, mem_rvalid, pc_load, stack_busy, bus_hold_enable;
  logic [7:0] cpu_rdata, mem_rdata, rd;
  logic mode_1m = 1'b0;
  logic call_start = 1'b0;
  logic ret_start = 1'b0;
  logic slow = 1'b0;
  logic [19:0] next_pc = '0;
  logic [19:0] target_pc = '0;
  logic [19:0] pc_q;
  logic [15:0] stack_top_pointer_q, sp;
  rwm_pkg::rwm_mem_s mem_req_b;
  logic rv_b, cpu_rvalid_b, mem_ready_b, mem_rvalid_b;
  logic [7:0] cpu_rdata_b, mem_rdata_b, rd_b;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;

  rwm_top #(.BLANK_MMSFR(1'b0), .PC_WIDTH(20)) dut_u (.clk(clk), .reset_n(reset_n),
    .cpu_req(cpu_req), .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
    .mem_req(mem_req), .mem_ready(mem_ready), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
    .mode_1m(mode_1m), .call_start(call_start), .ret_start(ret_start), .next_pc(next_pc),
    .target_pc(target_pc), .pc_q(pc_q), .pc_load(pc_load), .stack_busy(stack_busy),
    .bus_hold_enable(bus_hold_enable), .stack_top_pointer_q(stack_top_pointer_q));
  rwm_mem_model mem_u (.clk(clk), .req(mem_req), .slow(slow), .ready(mem_ready),
    .rdata(mem_rdata), .rvalid(mem_rvalid));
  // Blanking variant: same CPU traffic, its own memory.
  rwm_top #(.BLANK_MMSFR(1'b1), .PC_WIDTH(20)) dut_b (.clk(clk), .reset_n(reset_n),
    .cpu_req(cpu_req), .cpu_ready(), .cpu_rdata(cpu_rdata_b), .cpu_rvalid(cpu_rvalid_b),
    .mem_req(mem_req_b), .mem_ready(mem_ready_b), .mem_rdata(mem_rdata_b),
    .mem_rvalid(mem_rvalid_b), .mode_1m(mode_1m), .call_start(call_start),
    .ret_start(ret_start), .next_pc(next_pc), .target_pc(target_pc), .pc_q(), .pc_load(),
    .stack_busy(), .bus_hold_enable(), .stack_top_pointer_q());
  rwm_mem_model mem_b (.clk(clk), .req(mem_req_b), .slow(slow), .ready(mem_ready_b),
    .rdata(mem_rdata_b), .rvalid(mem_rvalid_b));

  // Free-running clock.
  initial begin
    forever #5 clk = ~clk;
  end

  // Cuts a hang short well past the expected run length.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One CPU byte access, held until taken; a read waits for its answer.
  task automatic acc(input logic wr, input rwm_pkg::rwm_mode_e md, input logic [15:0] a,
      input logic [7:0] d);
    @(negedge clk);
    cpu_req = '{1'b1, wr, md, a, d};
    #1;
    while (!cpu_ready) @(negedge clk);
    @(negedge clk);
    cpu_req.valid = 1'b0;
    while (!wr && !cpu_rvalid) @(negedge clk);
    rd = cpu_rdata;
    rd_b = cpu_rdata_b;
    rv_b = cpu_rvalid_b;
  endtask

  task automatic wait_load();
    int k;
    for (k = 0; k < 60 && !pc_load; k++) @(negedge clk);
    chk(20'(pc_load), 20'h1);
    @(negedge clk);
  endtask

  task automatic t_regs();
    acc(0, DR, 16'h0015, 8'h00); chk(20'(rd), 20'h0);
    acc(0, DR, 16'h0014, 8'h00); chk(20'(rd), 20'h0);
    acc(1, DR, 16'h0018, 8'h40);
    acc(1, DR, 16'h0019, 8'h02);
    acc(0, IN, 16'h0018, 8'h00); chk(20'(rd), 20'h40);
    acc(0, DR, 16'h0019, 8'h00); chk(20'(rd), 20'h02);
    chk(20'(stack_top_pointer_q), 20'h0240);
    acc(1, DR, 16'h0014, 8'h80); chk(20'(bus_hold_enable), 20'h1);
    acc(0, DR, 16'h0014, 8'h00); chk(20'(rd), 20'h80);
    acc(1, DR, 16'h0014, 8'h00); chk(20'(bus_hold_enable), 20'h0);
  endtask

  task automatic t_win();
    for (int i = 0; i < 11; i++) begin
      acc(1, IN, PA[i], 8'h50 + 8'(i));
      acc(1, DR, SEL[i], CODE[i]);
      acc(0, DR, LA[i], 8'h00); chk(20'(rd), 20'(8'h50 + 8'(i)));
      acc(1, DR, LA[i], 8'ha0 + 8'(i));
      acc(0, IN, PA[i], 8'h00); chk(20'(rd), 20'(8'ha0 + 8'(i)));
      acc(1, DR, SEL[i], 8'h00);
    end
  endtask

  task automatic t_modes();
    acc(1, IN, 16'h00eb, 8'h3c);
    acc(1, IX, 16'h014b, 8'hc3);
    acc(1, DR, 16'h0014, 8'h4a);
    acc(0, IN, 16'h00eb, 8'h00); chk(20'(rd), 20'h3c);
    acc(0, IX, 16'h014b, 8'h00); chk(20'(rd), 20'hc3);
    acc(1, DR, 16'h0015, 8'h25);
    acc(0, DR, 16'h00eb, 8'h00); chk(20'(rd), 20'hc3);
    acc(0, DR, 16'h004b, 8'h00); chk(20'(rd), 20'hc3);
    acc(1, DR, 16'h0030, 8'h5a);
    acc(0, IN, 16'h0030, 8'h00); chk(20'(rd), 20'h5a);
    acc(1, DR, 16'h0010, 8'h66);
    acc(0, IN, 16'h0010, 8'h00); chk(20'(rd), 20'h66);
    acc(1, DR, 16'h0014, 8'h00);
    acc(1, DR, 16'h0015, 8'h00);
    acc(0, DR, 16'h00eb, 8'h00); chk(20'(rd), 20'h3c);
  endtask

  // Top peripheral segment through a window: normal in one variant, blanked in the other.
  task automatic t_blank();
    acc(1, IN, 16'h1fe5, 8'h11);
    acc(1, DR, 16'h0014, 8'h7f);
    acc(1, DR, 16'h00e5, 8'h77);
    acc(0, DR, 16'h00e5, 8'h00); chk(20'({rv_b, rd_b, rd}), 20'h1ff77);
    acc(1, DR, 16'h0014, 8'h00);
    acc(0, IN, 16'h1fe5, 8'h00); chk(20'({rd, rd_b}), 20'h7711);
  endtask

  // Call then return in one addressing mode, with prompt or slow memory.
  task automatic t_stack(input logic m, input logic s);
    acc(1, DR, 16'h0018, 8'h40);
    acc(1, DR, 16'h0019, 8'h02);
    @(negedge clk);
    mode_1m = m;
    slow = s;
    next_pc = m ? 20'h5abcd : 20'h0abcd;
    target_pc = m ? 20'h91234 : 20'h01234;
    sp = m ? 16'h023c : 16'h023e;
    @(negedge clk);
    call_start = 1'b1;
    @(negedge clk);
    call_start = 1'b0;
    chk(20'({stack_busy, cpu_ready}), 20'h2);
    wait_load();
    chk(pc_q, target_pc);
    chk(20'(stack_top_pointer_q), 20'(sp));
    chk(20'(mem_u.mem[sp]), 20'hcd);
    chk(20'(mem_u.mem[sp + 16'h1]), 20'hab);
    if (m) chk(20'(mem_u.mem[sp + 16'h2][3:0]), 20'h5);
    ret_start = 1'b1;
    @(negedge clk);
    ret_start = 1'b0;
    wait_load();
    chk(pc_q, next_pc);
    chk(20'(stack_top_pointer_q), 20'h0240);
  endtask

  initial begin
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    t_regs();
    t_win();
    t_modes();
    t_blank();
    t_stack(1'b0, 1'b0);
    t_stack(1'b1, 1'b1);
    final_report();
  end
endmodule
